/* File: core/scpr_defs.svh */
// Constants for strap capture, pin roles, serial audio timing and clock-line filtering.
//
// Notes on behaviour
// - Power-up reset pin low holds device reset.
// - Bit clock pin: input slave, output master.
// - Bit clock runs 32 or 64 times fs.
// - Frame strobe driven as master, input slave.
// - Accept stereo stream on serial input pin.
// - Send stereo stream on serial output pin.
// - Test strap sampled in reset; low selects test.
// - Clock strap high selects bit clock reference.
// - Role strap high slave, low master.
// - Clock line ignores glitches, holds off changes.
`ifndef SCPR_DEFS_SVH
`define SCPR_DEFS_SVH

// ****************************************************************
// Timing of the core clock and the clock-line filter
// ****************************************************************
`define SCPR_CLK_PERIOD_NS 20
`define SCPR_GLITCH_NS     5
`define SCPR_HOLDOFF_NS    20
// Least time rounds up, longest time rounds down, never below one cycle.
`define SCPR_GLITCH_CYC_RAW  ((`SCPR_GLITCH_NS + `SCPR_CLK_PERIOD_NS - 1) / `SCPR_CLK_PERIOD_NS)
`define SCPR_GLITCH_CYC      ((`SCPR_GLITCH_CYC_RAW < 1) ? 1 : `SCPR_GLITCH_CYC_RAW)
`define SCPR_HOLDOFF_CYC_RAW (`SCPR_HOLDOFF_NS / `SCPR_CLK_PERIOD_NS)
`define SCPR_HOLDOFF_CYC     ((`SCPR_HOLDOFF_CYC_RAW < 1) ? 1 : `SCPR_HOLDOFF_CYC_RAW)
`define SCPR_FILT_CNT_W      4

// ****************************************************************
// Serial audio framing
// ****************************************************************
`define SCPR_BCLK_HALF_CYC 4'h8
`define SCPR_SLOT_BITS_32X 6'h10
`define SCPR_SLOT_BITS_64X 6'h20
`define SCPR_SAMPLE_W      24
`define SCPR_SHIFT_W       32
`define SCPR_PAD_64X       8
`define SCPR_PAD_32X       16
`define SCPR_SLOT_CNT_W    6
`define SCPR_DIV_CNT_W     4

// ****************************************************************
// Synchroniser lanes and strap defaults (pulled-up levels)
// ****************************************************************
`define SCPR_SYNC_W        8
`define SCPR_LANE_RST      0
`define SCPR_LANE_TEST     1
`define SCPR_LANE_REF      2
`define SCPR_LANE_ROLE     3
`define SCPR_LANE_BCLK     4
`define SCPR_LANE_FRAME    5
`define SCPR_LANE_SDI      6
`define SCPR_LANE_SCL      7
`define SCPR_SYNC_RESET    8'hff

`endif

/* File: core/scpr_pkg.sv */
// Types shared by the strap capture and pin role block.
package scpr_pkg;
  `include "scpr_defs.svh"

  // Straps as latched at the end of power-up reset.
  typedef struct packed {
    logic test_mode;
    logic pll_ref_bit_clock;
    logic two_wire_master;
  } scpr_straps_t;

  // Role of each shared pin: high means the audio or clock function.
  typedef struct packed {
    logic bit_clock_audio;
    logic frame_audio;
    logic sdi_audio;
    logic sdo_audio;
    logic aux_clock;
  } scpr_roles_t;

  // General-purpose values driven when a pin is not in its audio role.
  typedef struct packed {
    logic io_zero_out;
    logic io_zero_oe;
    logic io_one_out;
    logic io_one_oe;
    logic io_twenty_out;
    logic io_twenty_oe;
    logic out_six;
    logic out_seven;
    logic out_seventeen;
    logic out_eighteen;
  } scpr_gpio_t;

  // One stereo sample.
  typedef struct packed {
    logic [`SCPR_SAMPLE_W-1:0] left;
    logic [`SCPR_SAMPLE_W-1:0] right;
  } scpr_sample_t;

  // Link events seen in the core clock domain.
  typedef enum logic [1:0] {
    SCPR_EDGE_NONE = 2'b00,
    SCPR_EDGE_RISE = 2'b01,
    SCPR_EDGE_FALL = 2'b10
  } scpr_edge_t;
endpackage

/* File: core/scpr_scl_filter.sv */
// Glitch filter and change hold-off for the two-wire clock line.
module scpr_scl_filter (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Synchronised line level and the filtered result
  input  wire logic line_in,
  output logic      line_out
);
  import scpr_pkg::*;

  logic [`SCPR_FILT_CNT_W-1:0] stable_cnt;
  logic [`SCPR_FILT_CNT_W-1:0] hold_cnt;
  logic [`SCPR_FILT_CNT_W-1:0] next_stable_cnt;
  logic [`SCPR_FILT_CNT_W-1:0] next_hold_cnt;
  logic                        next_line_out;

  // ****************************************************************
  // Filter
  // ****************************************************************
  // A new level must persist before it is taken; after a change the
  // output is frozen so reflections cannot toggle it again.
  always_comb begin
    next_line_out   = line_out;
    next_stable_cnt = '0;
    next_hold_cnt   = (hold_cnt != '0) ? hold_cnt - 1'b1 : hold_cnt;
    if (rst) begin
      next_line_out = 1'b1;
      next_hold_cnt = '0;
    end else if (hold_cnt != '0) begin
      next_stable_cnt = '0;
    end else if (line_in != line_out) begin
      if (stable_cnt + 1'b1 >= `SCPR_FILT_CNT_W'(`SCPR_GLITCH_CYC)) begin
        next_line_out = line_in;
        next_hold_cnt = `SCPR_FILT_CNT_W'(`SCPR_HOLDOFF_CYC);
      end else begin
        next_stable_cnt = stable_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    line_out   <= next_line_out;
    stable_cnt <= next_stable_cnt;
    hold_cnt   <= next_hold_cnt;
  end
endmodule

/* File: core/scpr_sync.sv */
// Two-flip-flop synchroniser for pin inputs.
module scpr_sync (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Asynchronous levels and their synchronised copies
  input  wire logic [`SCPR_SYNC_W-1:0] async_in,
  output logic      [`SCPR_SYNC_W-1:0] sync_out
);
  import scpr_pkg::*;

  logic [`SCPR_SYNC_W-1:0] meta;
  logic [`SCPR_SYNC_W-1:0] next_meta;
  logic [`SCPR_SYNC_W-1:0] next_sync_out;

  // ****************************************************************
  // Next values
  // ****************************************************************
  // Reset to the pulled-up level so nothing looks asserted early.
  always_comb begin
    next_meta     = rst ? `SCPR_SYNC_RESET : async_in;
    next_sync_out = rst ? `SCPR_SYNC_RESET : meta;
  end

  // The first stage is read by the second stage only.
  always_ff @(posedge clk) begin
    meta     <= next_meta;
    sync_out <= next_sync_out;
  end
endmodule

/* File: core/scpr_top.sv */
// Strap capture, shared pin roles, serial audio framing and clock-line filtering.
module scpr_top (
  // Core clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Power-up reset pin
  input  wire logic                 power_up_reset_in_low,
  // Configuration
  input  wire logic                 audio_master,
  input  wire logic                 bit_clock_ratio_64,
  input  wire scpr_pkg::scpr_roles_t pin_roles,
  input  wire scpr_pkg::scpr_gpio_t  gpio_drive,
  // Bit clock pin, shared with general_io_zero
  input  wire logic                 serial_bit_clock_in,
  output logic                      serial_bit_clock_out,
  output logic                      serial_bit_clock_oe,
  // Frame strobe pin, shared with general_io_one
  input  wire logic                 frame_strobe_in,
  output logic                      frame_strobe_out,
  output logic                      frame_strobe_oe,
  // Serial data input pin, shared with general_io_twenty
  input  wire logic                 serial_audio_in_0_in,
  output logic                      serial_audio_in_0_out,
  output logic                      serial_audio_in_0_oe,
  // Serial data output pin, shares test strap and general_out_six
  input  wire logic                 serial_audio_out_0_in,
  output logic                      serial_audio_out_0_out,
  output logic                      serial_audio_out_0_oe,
  // Aux clock pin, shares clock-source strap and general_out_seven
  input  wire logic                 aux_clock_output_in,
  output logic                      aux_clock_output_out,
  output logic                      aux_clock_output_oe,
  // Role strap pin, shared with general_out_eighteen
  input  wire logic                 two_wire_role_strap_in,
  output logic                      two_wire_role_strap_out,
  output logic                      two_wire_role_strap_oe,
  // General output seventeen
  output logic                      general_out_seventeen,
  // Two-wire clock line, open drain
  input  wire logic                 two_wire_clock_in,
  input  wire logic                 two_wire_clock_pull_low,
  output logic                      two_wire_clock_out,
  output logic                      two_wire_clock_oe,
  output logic                      two_wire_clock_filtered,
  // Status
  output logic                      reset_active,
  output scpr_pkg::scpr_straps_t    straps,
  output logic [2:0]                general_io_in,
  // Audio samples
  input  wire scpr_pkg::scpr_sample_t tx_sample,
  output logic                      tx_sample_taken,
  output scpr_pkg::scpr_sample_t    rx_sample,
  output logic                      rx_sample_valid
);
  import scpr_pkg::*;

  // ****************************************************************
  // Pin synchronisers and the clock-line filter
  // ****************************************************************
  logic [`SCPR_SYNC_W-1:0] pins_s;
  logic                    scl_filt;

  scpr_sync u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({two_wire_clock_in, serial_audio_in_0_in, frame_strobe_in,
                serial_bit_clock_in, two_wire_role_strap_in, aux_clock_output_in,
                serial_audio_out_0_in, power_up_reset_in_low}),
    .sync_out (pins_s)
  );

  scpr_scl_filter u_scl_filter (
    .clk      (clk),
    .rst      (rst),
    .line_in  (pins_s[`SCPR_LANE_SCL]),
    .line_out (scl_filt)
  );

  // ****************************************************************
  // Reset and strap capture
  // ****************************************************************
  logic         in_reset;
  logic         next_reset_active;
  scpr_straps_t next_straps;

  // While reset stands the straps follow the pins; when it ends the last
  // sampled values stay frozen, so later output use cannot disturb them.
  always_comb begin
    in_reset          = rst | ~pins_s[`SCPR_LANE_RST];
    next_reset_active = in_reset;
    next_straps       = straps;
    if (in_reset) begin
      next_straps.test_mode         = ~pins_s[`SCPR_LANE_TEST];
      next_straps.pll_ref_bit_clock = pins_s[`SCPR_LANE_REF];
      next_straps.two_wire_master   = ~pins_s[`SCPR_LANE_ROLE];
    end
  end

  always_ff @(posedge clk) begin
    reset_active <= next_reset_active;
    straps       <= next_straps;
  end

  // ****************************************************************
  // Bit clock and frame strobe timing
  // ****************************************************************
  logic [`SCPR_DIV_CNT_W-1:0]  div_cnt;
  logic [`SCPR_SLOT_CNT_W-1:0] slot_cnt;
  logic                        bclk_gen;
  logic                        frame_gen;
  logic                        bclk_prev;
  logic                        frame_prev;
  logic [`SCPR_DIV_CNT_W-1:0]  next_div_cnt;
  logic [`SCPR_SLOT_CNT_W-1:0] next_slot_cnt;
  logic                        next_bclk_gen;
  logic                        next_frame_gen;
  logic                        next_bclk_prev;
  logic                        next_frame_prev;
  logic                        bclk_now;
  logic                        frame_now;
  logic [`SCPR_SLOT_CNT_W-1:0] slot_bits;
  scpr_edge_t                  bclk_edge;

  // As master the bit clock comes from a divider of the core clock and
  // the frame strobe flips after each slot; as slave both are sampled.
  always_comb begin
    slot_bits = bit_clock_ratio_64 ? `SCPR_SLOT_BITS_64X : `SCPR_SLOT_BITS_32X;
    bclk_now  = audio_master ? bclk_gen : pins_s[`SCPR_LANE_BCLK];
    frame_now = audio_master ? frame_gen : pins_s[`SCPR_LANE_FRAME];
    if (bclk_now & ~bclk_prev) begin
      bclk_edge = SCPR_EDGE_RISE;
    end else if (~bclk_now & bclk_prev) begin
      bclk_edge = SCPR_EDGE_FALL;
    end else begin
      bclk_edge = SCPR_EDGE_NONE;
    end
    next_div_cnt    = div_cnt + 1'b1;
    next_bclk_gen   = bclk_gen;
    next_frame_gen  = frame_gen;
    next_slot_cnt   = slot_cnt;
    next_bclk_prev  = bclk_now;
    next_frame_prev = frame_now;
    if (in_reset || !audio_master) begin
      next_div_cnt   = '0;
      next_bclk_gen  = 1'b0;
      next_frame_gen = 1'b0;
      next_slot_cnt  = '0;
    end else if (div_cnt == `SCPR_BCLK_HALF_CYC - 1'b1) begin
      next_div_cnt  = '0;
      next_bclk_gen = ~bclk_gen;
      if (bclk_gen) begin
        // Falling edge: count bits of the slot and flip the strobe.
        if (slot_cnt == slot_bits - 1'b1) begin
          next_slot_cnt  = '0;
          next_frame_gen = ~frame_gen;
        end else begin
          next_slot_cnt = slot_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    div_cnt    <= next_div_cnt;
    slot_cnt   <= next_slot_cnt;
    bclk_gen   <= next_bclk_gen;
    frame_gen  <= next_frame_gen;
    bclk_prev  <= next_bclk_prev;
    frame_prev <= next_frame_prev;
  end

  // ****************************************************************
  // Serial data in and out
  // ****************************************************************
  logic [`SCPR_SHIFT_W-1:0] rx_shift;
  logic [`SCPR_SHIFT_W-1:0] tx_shift;
  logic [`SCPR_SAMPLE_W-1:0] rx_left;
  logic                     rx_frame_seen;
  logic                     tx_frame_seen;
  logic [`SCPR_SAMPLE_W-1:0] tx_right;
  logic                     tx_bit;
  logic [`SCPR_SHIFT_W-1:0] next_rx_shift;
  logic [`SCPR_SHIFT_W-1:0] next_tx_shift;
  logic [`SCPR_SAMPLE_W-1:0] next_rx_left;
  logic                     next_rx_frame_seen;
  logic                     next_tx_frame_seen;
  logic [`SCPR_SAMPLE_W-1:0] next_tx_right;
  logic                     next_tx_bit;
  scpr_sample_t             next_rx_sample;
  logic                     next_rx_sample_valid;
  logic                     next_tx_sample_taken;
  logic [`SCPR_SAMPLE_W-1:0] rx_word;

  // Data are taken on the rising bit clock and launched on the falling
  // one. A change of the strobe closes the slot; strobe low is left.
  // Only the top bits of a slot are kept, so a 32-times clock carries
  // 16 significant bits per channel.
  always_comb begin
    rx_word = bit_clock_ratio_64 ? rx_shift[`SCPR_SHIFT_W-1:`SCPR_PAD_64X]
                                 : {rx_shift[`SCPR_PAD_32X-1:0], 8'h00};
    next_rx_shift        = rx_shift;
    next_tx_shift        = tx_shift;
    next_rx_left         = rx_left;
    next_rx_frame_seen   = rx_frame_seen;
    next_tx_frame_seen   = tx_frame_seen;
    next_tx_right        = tx_right;
    next_tx_bit          = tx_bit;
    next_rx_sample       = rx_sample;
    next_rx_sample_valid = 1'b0;
    next_tx_sample_taken = 1'b0;
    if (in_reset) begin
      next_rx_shift      = '0;
      next_tx_shift      = '0;
      next_rx_frame_seen = 1'b0;
      next_tx_frame_seen = 1'b0;
      next_tx_bit        = 1'b0;
    end else if (bclk_edge == SCPR_EDGE_RISE) begin
      next_rx_shift      = {rx_shift[`SCPR_SHIFT_W-2:0], pins_s[`SCPR_LANE_SDI]};
      next_rx_frame_seen = frame_now;
      if (frame_now != rx_frame_seen) begin
        if (rx_frame_seen) begin
          next_rx_sample       = '{left: rx_left, right: rx_word};
          next_rx_sample_valid = pin_roles.sdi_audio;
        end else begin
          next_rx_left = rx_word;
        end
      end
    end else if (bclk_edge == SCPR_EDGE_FALL) begin
      next_tx_frame_seen = frame_now;
      if (frame_now != tx_frame_seen) begin
        // Left slot starts: take a fresh stereo sample.
        if (!frame_now) begin
          next_tx_right        = tx_sample.right;
          next_tx_sample_taken = 1'b1;
          next_tx_bit          = tx_sample.left[`SCPR_SAMPLE_W-1];
          next_tx_shift        = {tx_sample.left[`SCPR_SAMPLE_W-2:0], 9'h000};
        end else begin
          next_tx_bit   = tx_right[`SCPR_SAMPLE_W-1];
          next_tx_shift = {tx_right[`SCPR_SAMPLE_W-2:0], 9'h000};
        end
      end else begin
        next_tx_bit   = tx_shift[`SCPR_SHIFT_W-1];
        next_tx_shift = {tx_shift[`SCPR_SHIFT_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    rx_shift        <= next_rx_shift;
    tx_shift        <= next_tx_shift;
    rx_left         <= next_rx_left;
    rx_frame_seen   <= next_rx_frame_seen;
    tx_frame_seen   <= next_tx_frame_seen;
    tx_right        <= next_tx_right;
    tx_bit          <= next_tx_bit;
    rx_sample       <= next_rx_sample;
    rx_sample_valid <= next_rx_sample_valid;
    tx_sample_taken <= next_tx_sample_taken;
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic [19:0] next_pins;
  logic [2:0]  next_general_io_in;

  // Every driver is computed here and registered below. Strap pins stay
  // undriven through reset so that only the resistors set their level.
  always_comb begin
    next_pins[0]  = pin_roles.bit_clock_audio ? bclk_gen : gpio_drive.io_zero_out;
    next_pins[1]  = ~in_reset & (pin_roles.bit_clock_audio ? audio_master
                                                           : gpio_drive.io_zero_oe);
    next_pins[2]  = pin_roles.frame_audio ? frame_gen : gpio_drive.io_one_out;
    next_pins[3]  = ~in_reset & (pin_roles.frame_audio ? audio_master
                                                       : gpio_drive.io_one_oe);
    next_pins[4]  = gpio_drive.io_twenty_out;
    next_pins[5]  = ~in_reset & ~pin_roles.sdi_audio & gpio_drive.io_twenty_oe;
    next_pins[6]  = pin_roles.sdo_audio ? tx_bit : gpio_drive.out_six;
    next_pins[7]  = ~in_reset;
    next_pins[8]  = pin_roles.aux_clock ? bclk_gen : gpio_drive.out_seven;
    next_pins[9]  = ~in_reset;
    next_pins[10] = gpio_drive.out_eighteen;
    next_pins[11] = ~in_reset;
    next_pins[12] = gpio_drive.out_seventeen;
    // Open drain: only ever pull low, the line rises by its resistor.
    next_pins[13] = 1'b0;
    next_pins[14] = ~in_reset & two_wire_clock_pull_low;
    next_pins[15] = scl_filt;
    next_pins[19:16] = 4'h0;
    next_general_io_in = {pins_s[`SCPR_LANE_SDI], pins_s[`SCPR_LANE_FRAME],
                          pins_s[`SCPR_LANE_BCLK]};
  end

  always_ff @(posedge clk) begin
    serial_bit_clock_out    <= next_pins[0];
    serial_bit_clock_oe     <= next_pins[1];
    frame_strobe_out        <= next_pins[2];
    frame_strobe_oe         <= next_pins[3];
    serial_audio_in_0_out   <= next_pins[4];
    serial_audio_in_0_oe    <= next_pins[5];
    serial_audio_out_0_out  <= next_pins[6];
    serial_audio_out_0_oe   <= next_pins[7];
    aux_clock_output_out    <= next_pins[8];
    aux_clock_output_oe     <= next_pins[9];
    two_wire_role_strap_out <= next_pins[10];
    two_wire_role_strap_oe  <= next_pins[11];
    general_out_seventeen   <= next_pins[12];
    two_wire_clock_out      <= next_pins[13];
    two_wire_clock_oe       <= next_pins[14];
    two_wire_clock_filtered <= next_pins[15];
    general_io_in           <= next_general_io_in;
  end
endmodule

/* File: test/scpr_checker.sv */
// Concurrent checks on the top module's ports.
module scpr_checker (
  // Clock, reset and configuration
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   power_up_reset_in_low,
  input wire logic                   audio_master,
  input wire scpr_pkg::scpr_roles_t  pin_roles,
  // Audio and strap pins
  input wire logic                   serial_bit_clock_out,
  input wire logic                   serial_bit_clock_oe,
  input wire logic                   frame_strobe_oe,
  input wire logic                   serial_audio_out_0_in,
  input wire logic                   serial_audio_out_0_oe,
  input wire logic                   aux_clock_output_in,
  input wire logic                   aux_clock_output_oe,
  input wire logic                   two_wire_role_strap_in,
  input wire logic                   two_wire_role_strap_oe,
  // Clock line and status
  input wire logic                   two_wire_clock_in,
  input wire logic                   two_wire_clock_filtered,
  input wire logic                   reset_active,
  input wire scpr_pkg::scpr_straps_t straps
);
  import scpr_pkg::*;
  // ****************************************
  // Assertions on the core clock
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rst_hold_a: assert property (!power_up_reset_in_low [*4] |-> reset_active)
    else $error("reset not held");
  // Only resistors set strap levels in reset.
  oe_off_a: assert property (reset_active |-> !(serial_bit_clock_oe || frame_strobe_oe ||
    serial_audio_out_0_oe || aux_clock_output_oe || two_wire_role_strap_oe))
    else $error("pin driven during reset");
  strap_hold_a: assert property (!reset_active && !$past(reset_active) |-> $stable(straps))
    else $error("straps changed");
  strap_test_a: assert property ((reset_active && $stable(serial_audio_out_0_in)) [*5]
    |-> straps.test_mode == !serial_audio_out_0_in) else $error("test strap wrong");
  strap_ref_a: assert property ((reset_active && $stable(aux_clock_output_in)) [*5]
    |-> straps.pll_ref_bit_clock == aux_clock_output_in) else $error("ref strap wrong");
  strap_role_a: assert property ((reset_active && $stable(two_wire_role_strap_in)) [*5]
    |-> straps.two_wire_master == !two_wire_role_strap_in) else $error("role strap wrong");
  bclk_dir_a: assert property ((!reset_active && pin_roles.bit_clock_audio &&
    $stable(audio_master)) [*3] |-> serial_bit_clock_oe == audio_master)
    else $error("bit clock oe wrong");
  frame_dir_a: assert property ((!reset_active && pin_roles.frame_audio &&
    $stable(audio_master)) [*3] |-> frame_strobe_oe == audio_master)
    else $error("frame strobe oe wrong");
  bclk_half_a: assert property (audio_master && $rose(serial_bit_clock_out) |->
    (serial_bit_clock_out || !audio_master) [*8] ##1 (!serial_bit_clock_out || !audio_master))
    else $error("bit clock half period wrong");
  scl_follow_a: assert property ($stable(two_wire_clock_in) [*6] |->
    two_wire_clock_filtered == two_wire_clock_in) else $error("filter stuck");
endmodule

bind scpr_top scpr_checker i_scpr_checker (.*);

/* File: test/scpr_peer.sv */
// Serial audio peer: slave-mode link source and output capture.
module scpr_peer (
  // Control and lines seen on the board
  input  wire logic        run,
  input  wire logic [47:0] word,
  input  wire logic        bit_clock,
  input  wire logic        frame,
  input  wire logic        sdo,
  // Driven lines and the captured left slot
  output logic             bclk_o,
  output logic             frame_o,
  output logic             data_o,
  output logic [31:0]      left_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0]  idx = 6'h00;
  logic [31:0] sh = 32'h0;
  logic [31:0] slot;
  logic        fr_q = 1'h1;
  initial {bclk_o, frame_o, data_o, left_seen} = {3'h2, 32'h0};
  // Idle: link clock stands still, released data line toggles.
  always begin
    #80;
    if (run) begin
      bclk_o = ~bclk_o;
      if (!bclk_o) begin
        frame_o = idx[5];
        slot = {idx[5] ? word[23:0] : word[47:24], 8'h00};
        data_o = slot[5'h1f - idx[4:0]];
        idx++;
      end
    end else begin
      data_o = ~data_o;
    end
  end
  // A new strobe level at a rising edge closes the slot.
  always @(posedge bit_clock) begin
    if (frame !== fr_q) begin
      if (!fr_q) left_seen = sh;
      sh = 32'h0;
    end
    sh = {sh[30:0], sdo};
    fr_q = frame;
  end
endmodule

/* File: test/scpr_tb_top.sv */
// Self-checking bench for the strap and pin role block.
module scpr_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import scpr_pkg::*;
  logic clk = 1'h0, rst = 1'h1, power_up_reset_in_low = 1'h1, audio_master = 1'h0;
  logic bit_clock_ratio_64 = 1'h1, two_wire_clock_pull_low = 1'h0, scl_drv = 1'h1;
  logic pd_test = 1'h0, pd_ref = 1'h0, pd_role = 1'h0, p_run = 1'h0;
  logic p_bclk, p_frame, p_data, tx_sample_taken, rx_sample_valid, general_out_seventeen;
  logic serial_bit_clock_in, serial_bit_clock_out, serial_bit_clock_oe;
  logic frame_strobe_in, frame_strobe_out, frame_strobe_oe;
  logic serial_audio_in_0_in, serial_audio_in_0_out, serial_audio_in_0_oe;
  logic serial_audio_out_0_in, serial_audio_out_0_out, serial_audio_out_0_oe;
  logic aux_clock_output_in, aux_clock_output_out, aux_clock_output_oe;
  logic two_wire_role_strap_in, two_wire_role_strap_out, two_wire_role_strap_oe;
  logic two_wire_clock_in, two_wire_clock_out, two_wire_clock_oe, two_wire_clock_filtered;
  logic reset_active;
  logic [2:0] general_io_in;
  logic [31:0] left_seen;
  logic [2:0] pats [2] = '{3'h5, 3'h2};
  scpr_roles_t pin_roles = 5'h1f;
  scpr_gpio_t gpio_drive = 10'h155;
  scpr_sample_t tx_sample = 48'habcdef_123456;
  scpr_sample_t p_word = 48'h5a1c3e_0f9b27;
  scpr_sample_t rx_sample;
  scpr_straps_t straps;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  // A pin shows its enabled driver, else peer or resistor.
  assign serial_bit_clock_in = serial_bit_clock_oe ? serial_bit_clock_out : p_bclk;
  assign frame_strobe_in = frame_strobe_oe ? frame_strobe_out : p_frame;
  assign serial_audio_in_0_in = serial_audio_in_0_oe ? serial_audio_in_0_out : p_data;
  assign serial_audio_out_0_in = serial_audio_out_0_oe ? serial_audio_out_0_out : !pd_test;
  assign aux_clock_output_in = aux_clock_output_oe ? aux_clock_output_out : !pd_ref;
  assign two_wire_role_strap_in = two_wire_role_strap_oe ? two_wire_role_strap_out : !pd_role;
  assign two_wire_clock_in = scl_drv && !two_wire_clock_oe;
  scpr_top i_scpr_top (.*);
  scpr_peer i_scpr_peer (.run(p_run), .word(p_word), .bit_clock(serial_bit_clock_in),
    .frame(frame_strobe_in), .sdo(serial_audio_out_0_in), .bclk_o(p_bclk),
    .frame_o(p_frame), .data_o(p_data), .left_seen(left_seen));
  // Core clock and the hang guard.
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (++cyc == 40000) begin
      fail_count++;
      summarize();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [47:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Counts pulses, bounded so a silent design cannot hang.
  task automatic wait_pulses(input int n, input bit rx);
    repeat (4000) begin
      @(negedge clk);
      if ((rx ? rx_sample_valid : tx_sample_taken) === 1'h1) n--;
      if (n == 0) break;
    end
  endtask
  task automatic scl_step(input logic drv, pull, exp);
    scl_drv = drv;
    two_wire_clock_pull_low = pull;
    repeat (8) @(negedge clk);
    chk("scl_filtered", 48'(exp), 48'(two_wire_clock_filtered));
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Straps, master stream, slave stream, clock line.
  initial begin
    logic [2:0] exp_s;
    repeat (4) @(negedge clk);
    rst = 1'h0;
    repeat (4) @(negedge clk);
    foreach (pats[i]) begin
      {pd_test, pd_ref, pd_role} = pats[i];
      exp_s = {pats[i][2], !pats[i][1], pats[i][0]};
      power_up_reset_in_low = 1'h0;
      repeat (8) @(negedge clk);
      chk("reset_active", 48'h1, 48'(reset_active));
      power_up_reset_in_low = 1'h1;
      repeat (6) @(negedge clk);
      chk("straps", 48'(exp_s), 48'(straps));
      {pd_test, pd_ref, pd_role} = ~pats[i];
      repeat (6) @(negedge clk);
      chk("straps_held", 48'(exp_s), 48'(straps));
    end
    $display("test straps done");
    audio_master = 1'h1;
    for (int r = 1; r >= 0; r--) begin
      bit_clock_ratio_64 = r[0];
      wait_pulses(3, 1'h0);
      chk("left_slot", 48'(r ? {tx_sample.left, 8'h00} : {16'h0, tx_sample.left[23:8]}),
        48'(left_seen));
      chk("master_oe", 48'h3, 48'({serial_bit_clock_oe, frame_strobe_oe}));
    end
    $display("test master stream done");
    audio_master = 1'h0;
    bit_clock_ratio_64 = 1'h1;
    p_run = 1'h1;
    wait_pulses(3, 1'h1);
    chk("rx_sample", p_word, rx_sample);
    chk("slave_oe", 48'h0, 48'({serial_bit_clock_oe, frame_strobe_oe}));
    p_run = 1'h0;
    $display("test slave stream done");
    scl_step(1'h0, 1'h0, 1'h0);
    scl_step(1'h1, 1'h0, 1'h1);
    #1 scl_drv = 1'h0;
    #3 scl_drv = 1'h1;
    scl_step(1'h1, 1'h0, 1'h1);
    scl_step(1'h1, 1'h1, 1'h0);
    $display("test clock line done");
    summarize();
  end
endmodule
